// file: hw/pwr_guard.sv
// Power-down, standby, keeper and program protection of a logic part.
// Assumes pins synchronous to clk_i and a plain register port.
// What this block does
// (R01) Either sleep pin high enters power-down.
// (R02) Power-down holds internal state and outputs.
// (R03) Pin changes ignored until sleep pin low.
// (R04) Sleep pin is not user I/O then.
// (R05) Sleep pin cell stays usable internally.
// (R06) Keeper holds last driven pin level.
// (R07) Idle logic drops into automatic standby.
// (R08) Unused low-power cells are turned down.
// (R09) Reset initialises registers, outputs follow polarity.
// (R10) System meets setup before first clock.
// (R11) Clocks stay still during power-up reset; the bench keeps clk_i running through reset.
// (R12) Programmed fuse refuses pattern read-back.
// (R13) User signature stays readable always.
// (R14) Interrupted programming locks and tri-states pins.
// (R15) Keepers hold pins during programming.
// (R16) Outputs slow unless fast is configured.
// (R17) Disabled test port gives four user pins.
// (R18) Fresh part holds the erased pattern.
// (R19) Leaving power-down resumes without reinitialising.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pwr_guard
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_pin_a_i,
  input wire logic sleep_pin_b_i,
  input wire logic [pwr_guard_pkg::N_PINS-1:0] pin_in_i,
  input wire logic [pwr_guard_pkg::N_PINS-1:0] pin_drv_i,
  input wire logic [pwr_guard_pkg::N_PINS-1:0] ext_drv_i,
  input wire logic [pwr_guard_pkg::N_PINS-1:0] ext_oe_i,
  input wire logic [pwr_guard_pkg::PORT_PINS-1:0] port_in_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [pwr_guard_pkg::N_PINS-1:0] pin_out_o,
  output logic [pwr_guard_pkg::N_PINS-1:0] pin_oe_o,
  output logic [pwr_guard_pkg::N_PINS-1:0] pin_fast_o,
  output logic [pwr_guard_pkg::PORT_PINS-1:0] port_user_o,
  output logic [pwr_guard_pkg::N_CELLS-1:0] cell_off_o,
  output logic cascade_o,
  output logic sleeping_o,
  output logic standby_o,
  output logic locked_o
);
  import pwr_guard_pkg::*;

  mode_e mode;
  mode_e next_mode;
  logic [CTRL_W-1:0] ctrl;
  logic [N_PINS-1:0] slew_fast;
  logic [N_PINS-1:0] polarity;
  logic [N_CELLS-1:0] cell_used;
  logic [N_CELLS-1:0] cell_lowpwr;
  logic [SIG_W-1:0] signature;
  logic [31:0] pattern;
  logic [N_PINS-1:0] core_q;
  logic [N_PINS-1:0] in_prev;
  logic [7:0] idle_cnt;
  logic [N_PINS-1:0] keep_level;
  logic sleep_req;
  logic active;
  logic wr_ok;
  pin_drive_s ext_drive;
  logic [N_PINS-1:0] drv_eff;

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  assign sleep_req = ctrl[CTRL_SLEEP_EN] && (sleep_pin_a_i || sleep_pin_b_i); // R01
  assign wr_ok = reg_wr_i && (mode != ST_LOCK);

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      ST_RUN:
        if (wr_ok && reg_addr_i == REG_PROG && reg_wdata_i[PROG_START])
          next_mode = ST_PROG;
        else if (sleep_req)
          next_mode = ST_SLEEP; // R01
      ST_SLEEP:
        if (!sleep_req)
          next_mode = ST_RUN; // R19
      // Abort outranks done when both bits arrive in one write.
      ST_PROG:
        if (reg_wr_i && reg_addr_i == REG_PROG && reg_wdata_i[PROG_ABORT])
          next_mode = ST_LOCK; // R14
        else if (reg_wr_i && reg_addr_i == REG_PROG && reg_wdata_i[PROG_DONE])
          next_mode = ST_RUN;
      // Only a fresh start leaves the locked state.
      ST_LOCK:
        if (reg_wr_i && reg_addr_i == REG_PROG && reg_wdata_i[PROG_START])
          next_mode = ST_PROG;
      default:
        next_mode = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode <= ST_RUN;
    else
      mode <= next_mode;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Configuration is only accepted while the part is being programmed.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= CTRL_RST;
      slew_fast <= SLEW_RST; // R16
      polarity <= POLARITY_RST;
      cell_used <= '0;
      cell_lowpwr <= '0;
      signature <= SIG_RST;
    end
    else if (mode == ST_PROG && reg_wr_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL: ctrl <= reg_wdata_i[CTRL_W-1:0];
        REG_SLEW: slew_fast <= reg_wdata_i[N_PINS-1:0]; // R16
        REG_CELL_USED: cell_used <= reg_wdata_i[N_CELLS-1:0];
        REG_CELL_LOWPWR: cell_lowpwr <= reg_wdata_i[N_CELLS-1:0];
        REG_SIG: signature <= reg_wdata_i[SIG_W-1:0];
        REG_STATUS: polarity <= reg_wdata_i[N_PINS-1:0];
        default: ;
      endcase
    end
  end

  // The configuration pattern is not kept over reset: every reset loads it erased.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pattern <= PATTERN_ERASED; // R18
    else if (mode == ST_PROG && reg_wr_i && reg_addr_i == REG_PATTERN)
      pattern <= reg_wdata_i;
  end

  // ----------------------------------------------------------------
  // User logic core and held state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      core_q <= '0; // R09
      in_prev <= '0;
    end
    else if (mode == ST_RUN)
    begin
      core_q <= pin_drv_i ^ pattern[N_PINS-1:0];
      in_prev <= pin_in_i;
    end
    // Sleep keeps both frozen, so pin changes are not seen. R02 R03
  end

  // Idle counter for automatic standby.
  assign active = (pin_in_i != in_prev) || (mode != ST_RUN);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      idle_cnt <= '0;
    else if (active)
      idle_cnt <= '0; // R07
    else if (idle_cnt != IDLE_COUNT)
      idle_cnt <= idle_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // Keeper
  // ----------------------------------------------------------------
  assign ext_drive.val = ext_drv_i;
  assign ext_drive.oe = ext_oe_i;

  // Keepers learn nothing while programming or asleep, as pins are ignored then.
  pin_keeper u_keeper
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .keeper_en_i(ctrl[CTRL_KEEPER_EN]),
    .hold_i((mode == ST_PROG) || (mode == ST_SLEEP)), // R03 R15
    .ext_i(ext_drive),
    .level_o(keep_level)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Each pin's buffer polarity flips the core value before it leaves.
  assign drv_eff = core_q ^ polarity; // R09

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_o <= POLARITY_RST;
      pin_oe_o <= '0;
      pin_fast_o <= '0;
    end
    else
    begin
      pin_fast_o <= slew_fast; // R16
      unique case (next_mode)
        ST_RUN:
        begin
          pin_out_o <= drv_eff;
          pin_oe_o <= ~ext_oe_i;
        end
        ST_SLEEP:
        begin
          pin_out_o <= pin_out_o; // R02
          pin_oe_o <= pin_oe_o;
        end
        ST_PROG:
        begin
          pin_out_o <= keep_level; // R15
          pin_oe_o <= {N_PINS{ctrl[CTRL_KEEPER_EN]}};
        end
        ST_LOCK:
        begin
          pin_out_o <= '0; // R14
          pin_oe_o <= '0;
        end
        default:
        begin
          pin_out_o <= '0;
          pin_oe_o <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sleeping_o <= 1'b0;
      standby_o <= 1'b0;
      locked_o <= 1'b0;
      cell_off_o <= '0;
    end
    else
    begin
      sleeping_o <= (next_mode == ST_SLEEP);
      // Standby only rises once the idle count has saturated with no activity.
      standby_o <= (idle_cnt == IDLE_COUNT) && !active; // R07
      locked_o <= (next_mode == ST_LOCK); // R14
      // A cell is turned down only if it is unused and marked for low power.
      cell_off_o <= cell_lowpwr & ~cell_used; // R08
    end
  end

  // Test-port pins act as user inputs; they are ignored while asleep.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      port_user_o <= '0;
    else if (next_mode != ST_SLEEP)
      port_user_o <= ctrl[CTRL_PORT_DIS] ? port_in_i : '0; // R17 R03
  end

  // Sleep pins feed no user logic; their cell still builds cascade. R04 R05
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cascade_o <= 1'b0;
    else if (mode == ST_RUN)
      cascade_o <= ^core_q;
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data stand for one cycle after each cycle of reg_rd_i and are zero otherwise.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL: reg_rdata_o <= 32'(ctrl);
        REG_STATUS: reg_rdata_o <= {24'h000000, mode, 1'b0, standby_o, locked_o,
                                    sleeping_o};
        REG_SIG: reg_rdata_o <= 32'(signature); // R13
        REG_PATTERN: reg_rdata_o <= ctrl[CTRL_FUSE] ? REFUSED_WORD : pattern; // R12
        REG_SLEW: reg_rdata_o <= 32'(slew_fast);
        REG_CELL_USED: reg_rdata_o <= 32'(cell_used);
        REG_CELL_LOWPWR: reg_rdata_o <= 32'(cell_lowpwr);
        default: reg_rdata_o <= '0;
      endcase
    end
    else
      reg_rdata_o <= '0;
  end
endmodule // pwr_guard

// file: hw/pwr_guard_pkg.sv
// Package for the power-down and program-protection block.
// Assumes a single 25 MHz clock and an active-low asynchronous reset.
package pwr_guard_pkg;

  localparam int unsigned N_PINS = 8;
  localparam int unsigned N_CELLS = 8;
  localparam int unsigned SIG_W = 16;
  localparam int unsigned PORT_PINS = 4;

  // Register index map on the plain register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_SIG = 4'h2;
  localparam logic [3:0] REG_PATTERN = 4'h3;
  localparam logic [3:0] REG_SLEW = 4'h4;
  localparam logic [3:0] REG_CELL_USED = 4'h5;
  localparam logic [3:0] REG_CELL_LOWPWR = 4'h6;
  localparam logic [3:0] REG_PROG = 4'h7;

  // Control field positions.
  localparam int unsigned CTRL_SLEEP_EN = 0;
  localparam int unsigned CTRL_KEEPER_EN = 1;
  localparam int unsigned CTRL_PORT_DIS = 2;
  localparam int unsigned CTRL_FUSE = 3;
  localparam int unsigned CTRL_W = 4;

  // Program register field positions.
  localparam int unsigned PROG_START = 0;
  localparam int unsigned PROG_DONE = 1;
  localparam int unsigned PROG_ABORT = 2;

  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [N_PINS-1:0] SLEW_RST = 8'h00;
  localparam logic [N_PINS-1:0] POLARITY_RST = 8'h00;
  localparam logic [31:0] PATTERN_ERASED = 32'hFFFFFFFF;
  localparam logic [SIG_W-1:0] SIG_RST = 16'h0000;
  localparam logic [31:0] REFUSED_WORD = 32'h00000000;

  // Idle cycles before automatic standby.
  localparam int unsigned IDLE_NS = 400;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] IDLE_COUNT = 8'(IDLE_CYC);

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_PROG = 4'b0100,
    ST_LOCK = 4'b1000
  } mode_e;

  typedef struct packed {
    logic [N_PINS-1:0] val;
    logic [N_PINS-1:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// file: hw/pin_keeper.sv
// Per-pin keeper: remembers the last driven level of each pin.
// Assumes pin levels are synchronous to clk_i.
`timescale 1ns/1ps
module pin_keeper
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic keeper_en_i,
  input wire logic hold_i,
  input wire pwr_guard_pkg::pin_drive_s ext_i,
  output logic [pwr_guard_pkg::N_PINS-1:0] level_o
);
  import pwr_guard_pkg::*;

  genvar g;
  generate
    for (g = 0; g < N_PINS; g++)
    begin : g_keep
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          level_o[g] <= 1'b0;
        else if (keeper_en_i && !hold_i && ext_i.oe[g])
          level_o[g] <= ext_i.val[g]; // R06
      end
    end
  endgenerate
endmodule // pin_keeper

// file: bench/pwr_guard_sva.sv
// Port checker for the power-guard block.
// Assumes it is bound to every pwr_guard instance.
`timescale 1ns/1ps
module pwr_guard_sva
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_pin_a_i,
  input wire logic sleep_pin_b_i,
  input wire logic [7:0] pin_in_i,
  input wire logic [3:0] port_in_i,
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [3:0] port_user_o,
  input wire logic cascade_o,
  input wire logic sleeping_o,
  input wire logic locked_o,
  input wire logic standby_o
);
  logic [3:0] quiet;
  // Counts clock edges with unchanged pin levels.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      quiet <= 4'h0;
    else if (!$stable(pin_in_i))
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_held;
    sleeping_o ##1 sleeping_o;
  endsequence
  a_sleep_hold: assert property (s_held |-> $stable(pin_out_o) && $stable(pin_oe_o))
    else $error("held pins moved");
  a_cascade_hold: assert property (s_held |-> $stable(cascade_o))
    else $error("cascade moved in sleep");
  a_sleep_cause: assert property (sleeping_o |-> $past(sleep_pin_a_i || sleep_pin_b_i))
    else $error("sleep without pin");
  a_sleep_stay: assert property ((sleep_pin_a_i || sleep_pin_b_i) && sleeping_o |=> sleeping_o)
    else $error("woke early");
  a_wake_prompt: assert property (sleeping_o && !sleep_pin_a_i && !sleep_pin_b_i |=> !sleeping_o)
    else $error("late wake");
  a_lock_float: assert property (locked_o |-> pin_oe_o == 8'h00 && pin_out_o == 8'h00)
    else $error("locked pins driven");
  a_port_follow: assert property (port_user_o != 4'h0 && !sleeping_o |-> port_user_o == $past(port_in_i))
    else $error("port pins wrong");
  a_port_freeze: assert property (s_held |-> $stable(port_user_o))
    else $error("port pins moved in sleep");
  a_standby_idle: assert property ($rose(standby_o) |-> quiet >= 4'h8)
    else $error("standby too soon");
endmodule // pwr_guard_sva
bind pwr_guard pwr_guard_sva chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_pin_a_i(sleep_pin_a_i),
  .sleep_pin_b_i(sleep_pin_b_i), .pin_in_i(pin_in_i), .port_in_i(port_in_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .port_user_o(port_user_o), .cascade_o(cascade_o),
  .sleeping_o(sleeping_o), .locked_o(locked_o), .standby_o(standby_o));

// file: bench/sys_side.sv
// System logic beside the part: sleep pins and outside pin drivers.
// Assumes requests from the bench, registered on clk_i.
`timescale 1ns/1ps
module sys_side
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] sleep_req_i,
  input wire logic [7:0] drive_req_i,
  input wire logic float_i,
  output logic sleep_a_o,
  output logic sleep_b_o,
  output logic [7:0] ext_drv_o,
  output logic [7:0] ext_oe_o
);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sleep_a_o <= 1'b0;
      sleep_b_o <= 1'b0;
      ext_oe_o <= 8'h00;
      ext_drv_o <= 8'h00;
    end
    else
    begin
      sleep_a_o <= sleep_req_i[0];
      sleep_b_o <= sleep_req_i[1];
      ext_oe_o <= float_i ? 8'h00 : 8'hFF;
      // A released line shows the inverse of its last level, never the level itself.
      ext_drv_o <= float_i ? ~drive_req_i : drive_req_i;
    end
  end
endmodule // sys_side

// file: bench/tb.sv
// Self-checking bench for pwr_guard.
// Assumes the sys_side partner model and the bound checker.
`timescale 1ns/1ps
module tb;
  import pwr_guard_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] sreq = 2'b00;
  logic [7:0] dreq = 8'h00;
  logic flt = 1'b1;
  logic [7:0] pin_in = 8'h00;
  logic [7:0] drv = 8'h00;
  logic [3:0] port_in = 4'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sa, sb, casc, slp, stby, lck;
  logic [7:0] xdrv, xoe, pout, poe, pfast, coff;
  logic [3:0] puser;
  logic [31:0] rdata;
  int num_errors = 0;
  int n_checks = 0;
  always #20 clk_i = ~clk_i;
  sys_side sys (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_req_i(sreq), .drive_req_i(dreq),
    .float_i(flt), .sleep_a_o(sa), .sleep_b_o(sb), .ext_drv_o(xdrv), .ext_oe_o(xoe));
  pwr_guard dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_pin_a_i(sa), .sleep_pin_b_i(sb),
    .pin_in_i(pin_in), .pin_drv_i(drv), .ext_drv_i(xdrv), .ext_oe_i(xoe), .port_in_i(port_in),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pin_out_o(pout), .pin_oe_o(poe), .pin_fast_o(pfast), .port_user_o(puser),
    .cell_off_o(coff), .cascade_o(casc), .sleeping_o(slp), .standby_o(stby), .locked_o(lck));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask
  task automatic t_reset();
    settle(1);
    chk({pout, poe, pfast, coff}, 32'h00FF0000, "outputs after reset");
    sreq <= 2'b11;
    reg_wr(REG_SLEW, 32'hFF);
    settle(3);
    chk(slp, 1'b0, "sleep while disabled");
    chk(pfast, SLEW_RST, "slew default");
    sreq <= 2'b00;
    reg_rd(REG_PATTERN, PATTERN_ERASED, "fresh pattern");
    reg_rd(4'h9, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_config();
    reg_wr(REG_PROG, 32'h1);
    reg_wr(REG_CTRL, 32'hF);
    reg_wr(REG_SIG, 32'hA5C3);
    reg_wr(REG_STATUS, 32'hF0);
    reg_wr(REG_SLEW, 32'h0F);
    reg_wr(REG_CELL_USED, 32'h0F);
    reg_wr(REG_CELL_LOWPWR, 32'h3C);
    reg_wr(REG_PROG, 32'h2);
    port_in <= 4'hA;
    settle(3);
    chk(pfast, 8'h0F, "fast slew");
    chk(coff, 8'h30, "cells off");
    chk(puser, 4'hA, "port as user pins");
    reg_rd(REG_PATTERN, REFUSED_WORD, "pattern hidden");
    reg_rd(REG_SIG, 32'hA5C3, "signature");
    $display("test config done");
  endtask
  task automatic t_sleep();
    for (int i = 0; i < 2; i++)
    begin
      drv <= 8'h3C;
      settle(3);
      chk({poe, pout}, 16'hFF33, "run outputs");
      sreq <= 2'(1 << i);
      settle(3);
      chk(slp, 1'b1, "asleep");
      drv <= 8'h99;
      pin_in <= 8'h55;
      port_in <= 4'h5;
      settle(3);
      chk({slp, pout}, 9'h133, "outputs held");
      chk(puser, 4'hA, "port pins ignored");
      sreq <= 2'b00;
      settle(4);
      chk({slp, pout}, 9'h096, "resumed");
      chk(puser, 4'h5, "port pins resumed");
      port_in <= 4'hA;
    end
    $display("test sleep done");
  endtask
  task automatic t_standby();
    settle(14);
    chk(stby, 1'b1, "standby");
    pin_in <= ~pin_in;
    settle(2);
    chk(stby, 1'b0, "standby left");
    $display("test standby done");
  endtask
  task automatic t_lock();
    flt <= 1'b0;
    dreq <= 8'h5A;
    settle(3);
    flt <= 1'b1;
    settle(3);
    reg_wr(REG_PROG, 32'h1);
    settle(2);
    chk({poe, pout}, 16'hFF5A, "keeper in prog");
    reg_wr(REG_PROG, 32'h6);
    settle(2);
    chk({lck, poe}, 9'h100, "locked");
    reg_rd(REG_STATUS, 32'h82, "status locked");
    reg_wr(REG_PROG, 32'h2);
    settle(2);
    chk(lck, 1'b1, "lock kept");
    reg_wr(REG_PROG, 32'h1);
    reg_wr(REG_PROG, 32'h2);
    settle(2);
    chk(lck, 1'b0, "lock left");
    $display("test lock done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_config();
    t_sleep();
    t_standby();
    t_lock();
    complete_run();
  end
endmodule // tb
